// ### ptrd_decoder.sv
// Purpose: Position reference pulse decoder and coincidence output
// Assumes: Speeds given as signed rpm, synchronous to mclk
// Notes: Host rate limits are not checked; too fast inputs lose counts
`timescale 1ns/1ps
`default_nettype none
`include "ptrd_cfg.svh"
module ptrd_decoder
    import ptrd_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int SPD_W = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic step_in, // Step / phase A / forward line
    input wire logic dir_in, // Direction / phase B / reverse line
    input wire logic [3:0] control_mode_select,
    input wire logic [2:0] pulse_form_digit,
    input wire logic [1:0] line_invert_digit,
    input wire logic [1:0] filter_select_digit,
    input wire logic [6:0] match_threshold,
    input wire logic signed [SPD_W-1:0] speed_cmd,
    input wire logic signed [SPD_W-1:0] speed_act,
    input wire logic position_done, // From position loop, high when done
    output logic [POS_W-1:0] pos_ref, // Accumulated reference
    output logic step_pulse, // One cycle per counted unit
    output logic step_fwd, // Direction of step_pulse
    output logic speed_match_n // Shared coincidence pin, low active
);
    // ************************************************************
    // Filter selection
    // ************************************************************
    localparam int FCW = 8;
    logic [FCW-1:0] stable_cycles; // Stable samples needed
    logic step_f; // Filtered step line
    logic dir_f; // Filtered direction line

    // Bandwidth picks the stable time
    always_comb begin
        case (filter_select_digit)
            `PTRD_FILT_650K: stable_cycles = FCW'(`PTRD_FLT1_CYC);
            `PTRD_FILT_150K: stable_cycles = FCW'(`PTRD_FLT2_CYC);
            default: stable_cycles = FCW'(`PTRD_FLT0_CYC);
        endcase
    end

    // Both lines synchronised then filtered
    ptrd_line_filter #(.CW(FCW)) u_flt_step (
        .mclk(mclk),
        .resetn(resetn),
        .line_in(step_in),
        .stable_cycles(stable_cycles),
        .line_out(step_f)
    );
    ptrd_line_filter #(.CW(FCW)) u_flt_dir (
        .mclk(mclk),
        .resetn(resetn),
        .line_in(dir_in),
        .stable_cycles(stable_cycles),
        .line_out(dir_f)
    );

    // ************************************************************
    // Inversion and edge detection
    // ************************************************************
    logic a_ln; // Step line after inversion
    logic b_ln; // Direction line after inversion
    logic a_prev_reg; // Previous step line
    logic b_prev_reg; // Previous direction line
    assign a_ln = step_f ^ line_invert_digit[`PTRD_INV_STEP_BIT];
    assign b_ln = dir_f ^ line_invert_digit[`PTRD_INV_DIR_BIT];

    // Delayed copies for edges
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            a_prev_reg <= 1'b0;
            b_prev_reg <= 1'b0;
        end else begin
            a_prev_reg <= a_ln;
            b_prev_reg <= b_ln;
        end
    end

    logic a_rise; // Rising edge on step line
    logic b_rise; // Rising edge on direction line
    logic a_chg; // Any edge on phase A
    logic b_chg; // Any edge on phase B
    assign a_rise = a_ln & ~a_prev_reg;
    assign b_rise = b_ln & ~b_prev_reg;
    assign a_chg = a_ln ^ a_prev_reg;
    assign b_chg = b_ln ^ b_prev_reg;

    // ************************************************************
    // Pulse form decoding
    // ************************************************************
    // Quadrature direction: B leads A is forward
    function automatic ptrd_step_e quad_dir(input logic a, input logic b, input logic a_edge);
        // On an A edge, B leads when B already sits at the new A level
        if (a_edge) begin
            quad_dir = (a == b) ? PTRD_FWD : PTRD_REV;
        end else begin
            // On a B edge, B leads when it has just left the A level
            quad_dir = (a != b) ? PTRD_FWD : PTRD_REV;
        end
    endfunction

    ptrd_step_e step_next; // Decoded event this cycle
    logic pos_mode; // Position control active

    assign pos_mode = (control_mode_select == `PTRD_MODE_POSITION);

    // Decode per form
    always_comb begin
        step_next = PTRD_HOLD;
        if (pos_mode) begin
            case (pulse_form_digit)
                `PTRD_FORM_STEPDIR: begin
                    // One unit per step, direction high is forward
                    if (a_rise) begin
                        step_next = b_ln ? PTRD_FWD : PTRD_REV;
                    end
                end
                `PTRD_FORM_FWDREV: begin
                    // Step line forward, direction line reverse
                    if (a_rise && !b_rise) begin
                        step_next = PTRD_FWD;
                    end else if (b_rise && !a_rise) begin
                        step_next = PTRD_REV;
                    end
                end
                `PTRD_FORM_QX1: begin
                    // One edge per cycle: A edge while B low
                    if (a_chg && !b_ln) begin
                        step_next = quad_dir(a_ln, b_ln, 1'b1);
                    end
                end
                `PTRD_FORM_QX2: begin
                    // Both edges of A
                    if (a_chg) begin
                        step_next = quad_dir(a_ln, b_ln, 1'b1);
                    end
                end
                `PTRD_FORM_QX4: begin
                    // Every edge of either phase while the other phase holds
                    if (a_chg && !b_chg) begin
                        step_next = quad_dir(a_ln, b_ln, 1'b1);
                    end else if (b_chg && !a_chg) begin
                        step_next = quad_dir(a_ln, b_ln, 1'b0);
                    end
                end
                default: step_next = PTRD_HOLD; // Unknown form ignored
            endcase
        end
    end

    // ************************************************************
    // Position accumulator
    // ************************************************************
    // Counts one unit per decoded event
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pos_ref <= '0;
            step_pulse <= 1'b0;
            step_fwd <= 1'b0;
        end else begin
            step_pulse <= (step_next != PTRD_HOLD);
            step_fwd <= (step_next == PTRD_FWD);
            if (step_next == PTRD_FWD) begin
                pos_ref <= pos_ref + 1'b1;
            end else if (step_next == PTRD_REV) begin
                pos_ref <= pos_ref - 1'b1;
            end
        end
    end

    // ************************************************************
    // Coincidence output
    // ************************************************************
    logic signed [SPD_W:0] spd_diff; // Signed speed error
    logic [SPD_W:0] spd_abs; // Magnitude of error
    logic [6:0] thresh_eff; // Threshold clamped to range
    assign spd_diff = (SPD_W+1)'(speed_cmd) - (SPD_W+1)'(speed_act);
    assign spd_abs = spd_diff[SPD_W] ? (SPD_W+1)'(-spd_diff) : spd_diff;
    assign thresh_eff = (match_threshold > `PTRD_THRESH_MAX) ? `PTRD_THRESH_MAX : match_threshold;

    // Threshold used live, no latching source per mode
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            speed_match_n <= 1'b1;
        end else if (pos_mode) begin
            speed_match_n <= ~position_done;
        end else begin
            speed_match_n <= ~(spd_abs < (SPD_W+1)'(thresh_eff));
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_mode_gate: assert property (@(posedge mclk) disable iff (!resetn)
        !pos_mode |=> !step_pulse)
        else $error("count outside position mode");
    chk_speed_match: assert property (@(posedge mclk) disable iff (!resetn)
        (!pos_mode && spd_abs < (SPD_W+1)'(thresh_eff)) |=> !speed_match_n)
        else $error("speed match not asserted");
    chk_speed_miss: assert property (@(posedge mclk) disable iff (!resetn)
        (!pos_mode && spd_abs >= (SPD_W+1)'(thresh_eff)) |=> speed_match_n)
        else $error("speed match wrongly asserted");
    chk_pos_done: assert property (@(posedge mclk) disable iff (!resetn)
        pos_mode |=> (speed_match_n == !$past(position_done)))
        else $error("position done not routed");
    chk_step_fwd: assert property (@(posedge mclk) disable iff (!resetn)
        (pos_mode && pulse_form_digit == `PTRD_FORM_STEPDIR && a_rise) |=> step_pulse && step_fwd == $past(b_ln))
        else $error("step direction wrong");
    chk_fwdrev_count: assert property (@(posedge mclk) disable iff (!resetn)
        (pos_mode && pulse_form_digit == `PTRD_FORM_FWDREV && b_rise && !a_rise) |=> step_pulse && !step_fwd)
        else $error("reverse pulse not counted");
    chk_quad_x4: assert property (@(posedge mclk) disable iff (!resetn)
        (pos_mode && pulse_form_digit == `PTRD_FORM_QX4 && (a_chg ^ b_chg)) |=> step_pulse)
        else $error("x4 edge missed");
    chk_quad_dir: assert property (@(posedge mclk) disable iff (!resetn)
        (pos_mode && pulse_form_digit == `PTRD_FORM_QX2 && a_chg) |=> step_fwd == ($past(a_ln) == $past(b_ln)))
        else $error("quadrature direction wrong");
    chk_pos_track: assert property (@(posedge mclk) disable iff (!resetn)
        step_pulse |-> pos_ref == $past(pos_ref) + (step_fwd ? 1 : -1))
        else $error("position not updated");
endmodule // ptrd_decoder
`default_nettype wire

// ### ptrd_cfg.svh
// Purpose: Constants for the pulse train reference decoder
// Assumes: 50 MHz mclk, all inputs synchronous to mclk
// Notes: Timing counts are derived from times in ns
`ifndef PTRD_CFG_SVH
`define PTRD_CFG_SVH

// ************************************************************
// Clock and filter timing
// ************************************************************
`define PTRD_CLK_NS 20
// Minimum stable time per filter setting, half period of max rate
`define PTRD_FLT0_NS 120
`define PTRD_FLT1_NS 760
`define PTRD_FLT2_NS 3300
// Cycles, rounded down, at least one
`define PTRD_FLT0_CYC ((`PTRD_FLT0_NS / `PTRD_CLK_NS) > 0 ? (`PTRD_FLT0_NS / `PTRD_CLK_NS) : 1)
`define PTRD_FLT1_CYC (`PTRD_FLT1_NS / `PTRD_CLK_NS)
`define PTRD_FLT2_CYC (`PTRD_FLT2_NS / `PTRD_CLK_NS)

// ************************************************************
// Parameter codes
// ************************************************************
`define PTRD_MODE_SPEED 4'h0
`define PTRD_MODE_POSITION 4'h1
`define PTRD_THRESH_DEFAULT 7'h0a
`define PTRD_THRESH_MAX 7'h64
`define PTRD_FILT_4M 2'h0
`define PTRD_FILT_650K 2'h1
`define PTRD_FILT_150K 2'h2
`define PTRD_FORM_STEPDIR 3'h0
`define PTRD_FORM_FWDREV 3'h1
`define PTRD_FORM_QX1 3'h2
`define PTRD_FORM_QX2 3'h3
`define PTRD_FORM_QX4 3'h4
`define PTRD_INV_DIR_BIT 0
`define PTRD_INV_STEP_BIT 1

`endif

// ### ptrd_pkg.sv
// Purpose: Types for the pulse train reference decoder
// Assumes: Used with ptrd_cfg.svh
// Notes: Holds types only
`default_nettype none
package ptrd_pkg;
    // Pulse decoding forms
    typedef logic [2:0] ptrd_form_t;
    // Count step result
    typedef enum logic [1:0] {
        PTRD_HOLD,
        PTRD_FWD,
        PTRD_REV
    } ptrd_step_e;
endpackage
`default_nettype wire

// ### ptrd_line_filter.sv
// Purpose: Synchronise and deglitch one reference line
// Assumes: Input synchronous enough for a two-stage sampler
// Notes: Output changes only after a stable run of samples
`timescale 1ns/1ps
`default_nettype none
`include "ptrd_cfg.svh"
module ptrd_line_filter #(
    parameter int CW = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic line_in,
    input wire logic [CW-1:0] stable_cycles,
    output logic line_out
);
    // ************************************************************
    // Synchroniser
    // ************************************************************
    logic sync1_reg; // First stage, read only by second stage
    logic sync2_reg; // Second stage
    logic [CW-1:0] run_reg; // Cycles of disagreement seen

    // Two flip-flop sampler
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= line_in;
            sync2_reg <= sync1_reg;
        end
    end

    // ************************************************************
    // Stability filter
    // ************************************************************
    // A change is accepted after it held for stable_cycles samples
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_reg <= '0;
            line_out <= 1'b0;
        end else if (sync2_reg == line_out) begin
            // Agreement resets the run
            run_reg <= '0;
        end else if (run_reg + 1'b1 >= stable_cycles) begin
            // Long enough: take it
            line_out <= sync2_reg;
            run_reg <= '0;
        end else begin
            run_reg <= run_reg + 1'b1;
        end
    end
endmodule // ptrd_line_filter
`default_nettype wire

// ### ptrd_host_model.sv
// Purpose: Host controller model driving the two reference lines
// Assumes: Lines change 1 ns after the mclk rise
// Notes: Callers pick half periods; the short ones in t_filter exceed the host rate limits
`timescale 1ns/1ps
`default_nettype none
module ptrd_host_model (
    input wire logic mclk,
    output logic line_a,
    output logic line_b
);
    // ************************************************************
    // Line drive
    // ************************************************************
    // Both lines idle low, as an unselected host output
    initial begin
        line_a = 1'b0;
        line_b = 1'b0;
    end
    // Set both wire levels, hold them, land just past an edge
    task automatic put(input logic a, input logic b, input int hold);
        line_a = a;
        line_b = b;
        repeat (hold) @(posedge mclk);
        #1;
    endtask
    // Half of 65 cycles stays under 500kpps and 200kpps at x4
    task automatic send(input logic [2:0] form, input int n, input logic fwd, input int half);
        logic [1:0] ph;
        ph = 2'b00;
        // Direction set up before the first step edge
        put(1'b0, fwd && form == 3'h0, half);
        for (int i = 0; i < n; i++) begin
            if (form >= 3'h2) begin
                // Gray walk of {A,B}; B leads A going forward
                for (int k = 0; k < 4; k++) begin
                    ph = fwd ? {ph[0], ~ph[1]} : {~ph[0], ph[1]};
                    put(ph[1], ph[0], half);
                end
            end else if (form == 3'h1) begin
                // One line pulses, the other stays low
                put(fwd, ~fwd, half);
                put(1'b0, 1'b0, half);
            end else begin
                put(1'b1, fwd, half);
                put(1'b0, fwd, half);
            end
        end
        put(1'b0, 1'b0, half);
    endtask
endmodule // ptrd_host_model
`default_nettype wire

// ### pulse_train_reference_decoder_tb_top.sv
// Purpose: Self-checking bench for the pulse train reference decoder
// Assumes: Filter settle fits in 300 cycles
// Notes: Counts judged by pos_ref and by a signed step tally
`timescale 1ns/1ps
`default_nettype none
`include "ptrd_cfg.svh"
module pulse_train_reference_decoder_tb_top;
    import ptrd_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic mclk, resetn, step_in, dir_in, position_done;
    logic [3:0] control_mode_select;
    logic [2:0] pulse_form_digit;
    logic [1:0] line_invert_digit, filter_select_digit;
    logic [6:0] match_threshold;
    logic signed [15:0] speed_cmd, speed_act;
    logic [31:0] pos_ref;
    logic step_pulse, step_fwd, speed_match_n;
    int err_total = 0, checks = 0, snet = 0;
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    ptrd_host_model u_ptrd_host_model (.mclk(mclk), .line_a(step_in), .line_b(dir_in));
    ptrd_decoder u_ptrd_decoder (.mclk(mclk), .resetn(resetn), .step_in(step_in), .dir_in(dir_in),
        .control_mode_select(control_mode_select), .pulse_form_digit(pulse_form_digit),
        .line_invert_digit(line_invert_digit), .filter_select_digit(filter_select_digit),
        .match_threshold(match_threshold), .speed_cmd(speed_cmd), .speed_act(speed_act),
        .position_done(position_done), .pos_ref(pos_ref), .step_pulse(step_pulse),
        .step_fwd(step_fwd), .speed_match_n(speed_match_n));
    // Signed tally of counted units, independent of pos_ref
    always @(posedge mclk) if (step_pulse === 1'b1) snet <= snet + (step_fwd === 1'b1 ? 1 : -1);
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (300) @(posedge mclk);
        #1;
    endtask
    // Send a burst and compare the net count
    task automatic go(input logic [2:0] form, input int n, input logic fwd, input int half, input int exp);
        logic [31:0] p0;
        int s0;
        pulse_form_digit = form;
        p0 = pos_ref;
        s0 = snet;
        u_ptrd_host_model.send(form, n, fwd, half);
        settle();
        check("pos_ref", pos_ref - p0, exp);
        check("step_net", snet - s0, exp);
    endtask
    // Change inversion with the lines still, expect edges it creates
    task automatic flip(input logic [1:0] inv, input int exp);
        logic [31:0] p0;
        p0 = pos_ref;
        line_invert_digit = inv;
        settle();
        check("inv_count", pos_ref - p0, exp);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_forms;
        int mult[5] = '{1, 1, 1, 2, 4};
        for (int f = 0; f < 5; f++) begin
            go(f[2:0], 2, 1'b1, 65, 2 * mult[f]);
            go(f[2:0], 2, 1'b0, 65, -2 * mult[f]);
        end
        go(3'h5, 2, 1'b1, 65, 0);
        $display("t_forms done");
    endtask
    task automatic t_invert;
        line_invert_digit = 2'h1;
        go(3'h0, 2, 1'b1, 65, -2);
        flip(2'h0, 0);
        u_ptrd_host_model.put(1'b0, 1'b1, 1);
        flip(2'h1, 0);
        flip(2'h3, -1);
        flip(2'h0, 0);
        flip(2'h2, 1);
        flip(2'h0, 0);
        u_ptrd_host_model.put(1'b0, 1'b0, 1);
        $display("t_invert done");
    endtask
    // Pulses a little under the filter time vanish, a little over count
    task automatic t_filter;
        int flt[3] = '{`PTRD_FLT0_CYC, `PTRD_FLT1_CYC, `PTRD_FLT2_CYC};
        for (int s = 0; s < 3; s++) begin
            filter_select_digit = s[1:0];
            go(3'h0, 1, 1'b1, flt[s] - 5, 0);
            go(3'h0, 1, 1'b1, flt[s] + 5, 1);
        end
        filter_select_digit = `PTRD_FILT_4M;
        $display("t_filter done");
    endtask
    task automatic t_mode;
        control_mode_select = `PTRD_MODE_SPEED;
        go(3'h0, 2, 1'b1, 65, 0);
        control_mode_select = `PTRD_MODE_POSITION;
        $display("t_mode done");
    endtask
    // Rows: mode, threshold, command, actual, done, expected pin
    task automatic t_speed;
        int tv[9][6] = '{'{0, 100, 2000, 1900, 0, 1}, '{0, 100, 2000, 1901, 0, 0}, '{2, 10, -5, 4, 0, 0},
            '{0, 10, 0, 10, 0, 1}, '{0, 0, 5, 5, 0, 1}, '{0, 120, 0, 100, 0, 1}, '{0, 120, 0, 99, 0, 0},
            '{1, 10, 0, 0, 0, 1}, '{1, 10, 0, 500, 1, 0}};
        for (int i = 0; i < 9; i++) begin
            control_mode_select = tv[i][0][3:0];
            match_threshold = tv[i][1][6:0];
            speed_cmd = tv[i][2][15:0];
            speed_act = tv[i][3][15:0];
            position_done = tv[i][4][0];
            repeat (2) @(posedge mclk);
            #1;
            check("speed_match_n", {31'h0, speed_match_n}, tv[i][5]);
        end
        $display("t_speed done");
    endtask
    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        resetn = 1'b0;
        control_mode_select = `PTRD_MODE_POSITION;
        pulse_form_digit = `PTRD_FORM_STEPDIR;
        line_invert_digit = 2'h0;
        filter_select_digit = `PTRD_FILT_4M;
        match_threshold = `PTRD_THRESH_DEFAULT;
        speed_cmd = 16'h0000;
        speed_act = 16'h0000;
        position_done = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        resetn = 1'b1;
        settle();
        t_forms();
        t_invert();
        t_filter();
        t_mode();
        t_speed();
        wrap_up();
    end
    initial begin
        repeat (80000) @(posedge mclk);
        err_total++;
        $display("Error watchdog expected finish seen hang");
        wrap_up();
    end
endmodule // pulse_train_reference_decoder_tb_top
`default_nettype wire
